// file: sshc_pkg.sv
// shared constants and types of the standby halt/stop controller
package sshc_pkg;
    // instruction kinds presented by the sequencer
    typedef enum logic [1:0] {
        SSHC_HALT = 2'h0,
        SSHC_STOP = 2'h1,
        SSHC_EI   = 2'h2,
        SSHC_DI   = 2'h3
    } sshc_instr_t;

    // gray codes along run -> halt and stop -> wait -> run; run -> stop flips both bits
    typedef enum logic [1:0] {
        SSHC_RUN  = 2'h0,
        SSHC_HLT  = 2'h1,
        SSHC_STP  = 2'h3,
        SSHC_WAIT = 2'h2
    } sshc_state_t;

    // one bit per interrupt source
    typedef struct packed {
        logic tm;
        logic ext;
        logic wtm;
        logic sio;
    } sshc_irq_t;

    localparam logic [3:0]  OPER_TIMER    = 4'h2;
    localparam logic [3:0]  OPER_ANY      = 4'h8;
    localparam logic [3:0]  OPER_TIMER_EN = 4'ha;

    localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
    localparam int          CTRL_SYSCLK   = 0;
    localparam int          CTRL_SUBCLK   = 1;
    localparam int          CTRL_TMM_LSB  = 8;
    localparam int          STAT_VEC      = 4;
    localparam int          STAT_NOP      = 5;
    localparam int          STAT_PORT     = 6;
    localparam logic [7:0]  TMM_RESET     = 8'hff;
    localparam logic        SYSCLK_RESET  = 1'b1;
    localparam int          PRESCALE_DIV  = 1024;
endpackage

// file: sshc_sync2.sv
// two flip-flop synchroniser for pin levels
module sshc_sync2 #(
    parameter int        W       = 4,
    parameter logic [3:0] RST_VAL = 4'hf
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= RST_VAL[W-1:0];
            dout <= RST_VAL[W-1:0];
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // sshc_sync2

// file: sshc_ctrl.sv
// standby controller: halt, stop, wake-up and stabilisation wait, ahb-lite registers
// What this block does
// - qualified halt freezes execution, main oscillator keeps running until wake
// - qualified stop freezes execution and turns the main oscillator off
// - halt operand 2 wakes only on the timer match request flag
// - halt operand 8 wakes on any enabled request or port A low
// - halt operand A wakes on any timer request or enabled other request
// - port A wake from halt 8 resumes at next instruction regardless of enables
// - interrupt wake vectors when master and own enable set, else next instruction
// - requests with enable 0 keep the block in standby for operand 8, and for A except the timer request
// - halt with unmet conditions or other operand acts as no-operation
// - halt 8 needs no enabled request, port A high/output, port B outputs at 0
// - stop is a no-operation while subclock is the system clock
// - stop 8 wakes on enabled watch/serial/pin request or port A low
// - stop needs no enabled request other than the timer, and the same port A and B conditions
// - stop release clears timer flag, restarts watch timers unless subclock in use, resets 8-bit timer
// - after stop, execution waits (modulo+1) times 1024 main clock periods
// - with subclock in use, watch and watchdog timers run through stop
// - master enable set by enable, cleared by disable and reset, unreadable
//
// Implementation choices: the register addresses and register access over AHB-Lite.
module sshc_ctrl #(
    parameter int PRESCALE = sshc_pkg::PRESCALE_DIV
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic      [31:0]           hrdata,
    // instruction sequencer
    input  wire logic                  instr_valid,
    input  wire sshc_pkg::sshc_instr_t instr_kind,
    input  wire logic [3:0]            instr_operand,
    output logic                       cpu_hold,
    output logic                       resume_pulse,
    output logic                       take_vector,
    output logic                       instr_as_nop,
    output logic                       master_irq_enable,
    // interrupt flags and peripherals
    input  wire sshc_pkg::sshc_irq_t   req_flags,
    input  wire sshc_pkg::sshc_irq_t   req_enables,
    output logic                       timer_match_flag_clear,
    output logic                       timer8_restart,
    output logic                       watch_restart,
    output logic                       watch_run,
    output logic                       main_osc_en,
    // ports
    input  wire logic [3:0]            wake_port_a,
    input  wire logic [3:0]            port_a_is_output,
    input  wire logic [3:0]            port_b_is_output,
    input  wire logic [3:0]            port_b_latch
);
    localparam int PW = $clog2(PRESCALE);

    sshc_pkg::sshc_state_t state;
    sshc_pkg::sshc_state_t next_state;
    logic [3:0]            halt_mode;
    logic [3:0]            pa_sync;
    logic                  system_clock_select;
    logic                  subclk_in_use;
    logic [7:0]            timer_modulo_value;
    logic [PW-1:0]         pre_cnt;
    logic [7:0]            stab_cnt;
    logic                  stop_vec;
    logic                  last_vec;
    logic                  last_nop;
    logic                  last_port;
    logic                  dp_write;
    logic [31:0]           dp_addr;
    logic                  pa_low;
    logic                  pa_ok;
    logic                  pb_ok;
    logic                  halt_ok;
    logic                  stop_ok;
    logic                  halt_wake;
    logic                  stop_wake;
    logic                  wait_done;
    logic                  is_halt;
    logic                  is_stop;
    logic                  pre_wrap;
    logic                  addr_phase;

    // any request pending whose own enable is set, timer source optional
    function automatic logic en_pending(input sshc_pkg::sshc_irq_t r,
                                        input sshc_pkg::sshc_irq_t e,
                                        input logic                with_tm);
        en_pending = (r.ext & e.ext) | (r.wtm & e.wtm) | (r.sio & e.sio)
                     | (with_tm & r.tm & e.tm);
    endfunction

    // port A pins are pins: synchronise before any use; stop wake levels
    // are static so resampling when the clock returns loses nothing
    sshc_sync2 #(.W(4), .RST_VAL(4'hf)) u_pa_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (wake_port_a),
        .dout (pa_sync)
    );

    // port and flag qualifiers for entry and wake
    assign pa_low  = |(~pa_sync & ~port_a_is_output);
    assign pa_ok   = ~pa_low;
    assign pb_ok   = (&port_b_is_output) & ~(|port_b_latch);
    assign is_halt = instr_valid && (instr_kind == sshc_pkg::SSHC_HALT);
    assign is_stop = instr_valid && (instr_kind == sshc_pkg::SSHC_STOP);

    // entry qualification per operand; everything else is a no-op
    always_comb begin
        unique case (instr_operand)
            sshc_pkg::OPER_TIMER:    halt_ok = ~req_flags.tm;
            sshc_pkg::OPER_ANY:      halt_ok = ~en_pending(req_flags, req_enables, 1'b1)
                                               & pa_ok & pb_ok;
            sshc_pkg::OPER_TIMER_EN: halt_ok = ~req_flags.tm
                                               & ~en_pending(req_flags, req_enables, 1'b0);
            default:                 halt_ok = 1'b0;
        endcase
    end

    // stop needs main clock as system clock plus quiet flags and ports
    assign stop_ok = (instr_operand == sshc_pkg::OPER_ANY) && system_clock_select
                     && ~en_pending(req_flags, req_enables, 1'b0) && pa_ok && pb_ok;

    // wake conditions; disabled requests do not count except the halt-2/A timer
    always_comb begin
        unique case (halt_mode)
            sshc_pkg::OPER_TIMER:    halt_wake = req_flags.tm;
            sshc_pkg::OPER_ANY:      halt_wake = en_pending(req_flags, req_enables, 1'b1)
                                                 | pa_low;
            default:                 halt_wake = req_flags.tm
                                                 | en_pending(req_flags, req_enables, 1'b0);
        endcase
    end
    assign stop_wake = en_pending(req_flags, req_enables, 1'b0) | pa_low;

    // stabilisation wait: prescaler of PRESCALE cycles, counter up to modulo
    assign pre_wrap  = (pre_cnt == PW'(PRESCALE - 1));
    assign wait_done = pre_wrap && (stab_cnt == timer_modulo_value);

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            sshc_pkg::SSHC_RUN: begin
                if (is_halt && halt_ok) begin
                    next_state = sshc_pkg::SSHC_HLT;
                end else if (is_stop && stop_ok) begin
                    next_state = sshc_pkg::SSHC_STP;
                end
            end
            sshc_pkg::SSHC_HLT:  if (halt_wake) next_state = sshc_pkg::SSHC_RUN;
            sshc_pkg::SSHC_STP:  if (stop_wake) next_state = sshc_pkg::SSHC_WAIT;
            sshc_pkg::SSHC_WAIT: if (wait_done) next_state = sshc_pkg::SSHC_RUN;
        endcase
    end

    // state and latched halt operand
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= sshc_pkg::SSHC_RUN;
            halt_mode <= 4'h0;
        end else begin
            state <= next_state;
            if (state == sshc_pkg::SSHC_RUN && is_halt) begin
                halt_mode <= instr_operand;
            end
        end
    end

    // stabilisation counters restart with the 8-bit timer on stop release
    always_ff @(posedge clk) begin
        if (rst || state != sshc_pkg::SSHC_WAIT) begin
            pre_cnt  <= '0;
            stab_cnt <= 8'h00;
        end else begin
            pre_cnt <= pre_wrap ? '0 : pre_cnt + PW'(1);
            if (pre_wrap) begin
                stab_cnt <= stab_cnt + 8'h01;
            end
        end
    end

    // sequencer outputs, all registered; hold and resume from the next state
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_hold     <= 1'b0;
            resume_pulse <= 1'b0;
            take_vector  <= 1'b0;
            instr_as_nop <= 1'b0;
            stop_vec     <= 1'b0;
        end else begin
            cpu_hold     <= next_state != sshc_pkg::SSHC_RUN;
            resume_pulse <= state != sshc_pkg::SSHC_RUN && next_state == sshc_pkg::SSHC_RUN;
            instr_as_nop <= state == sshc_pkg::SSHC_RUN
                            && ((is_halt && !halt_ok) || (is_stop && !stop_ok));
            if (state == sshc_pkg::SSHC_STP && stop_wake) begin
                stop_vec <= master_irq_enable & en_pending(req_flags, req_enables, 1'b0);
            end
            if (state == sshc_pkg::SSHC_HLT && halt_wake) begin
                // port wake alone never vectors; requests vector only when enabled
                take_vector <= master_irq_enable
                               & en_pending(req_flags, req_enables, 1'b1);
            end else if (state == sshc_pkg::SSHC_WAIT && wait_done) begin
                take_vector <= stop_vec;
            end else begin
                take_vector <= 1'b0;
            end
        end
    end

    // peripheral side: oscillator, timer restarts, watch timer run
    always_ff @(posedge clk) begin
        if (rst) begin
            main_osc_en            <= 1'b1;
            watch_run              <= 1'b1;
            timer_match_flag_clear <= 1'b0;
            timer8_restart         <= 1'b0;
            watch_restart          <= 1'b0;
        end else begin
            main_osc_en            <= next_state != sshc_pkg::SSHC_STP;
            watch_run              <= next_state != sshc_pkg::SSHC_STP || subclk_in_use;
            timer_match_flag_clear <= state == sshc_pkg::SSHC_STP && stop_wake;
            timer8_restart         <= state == sshc_pkg::SSHC_STP && stop_wake;
            watch_restart          <= state == sshc_pkg::SSHC_STP && stop_wake
                                      && !subclk_in_use;
        end
    end

    // master enable: not mapped for reads on purpose
    always_ff @(posedge clk) begin
        if (rst) begin
            master_irq_enable <= 1'b0;
        end else if (instr_valid && instr_kind == sshc_pkg::SSHC_EI) begin
            master_irq_enable <= 1'b1;
        end else if (instr_valid && instr_kind == sshc_pkg::SSHC_DI) begin
            master_irq_enable <= 1'b0;
        end
    end

    // status history for software
    always_ff @(posedge clk) begin
        if (rst) begin
            last_vec  <= 1'b0;
            last_nop  <= 1'b0;
            last_port <= 1'b0;
        end else begin
            if (resume_pulse) last_vec <= take_vector;
            if (instr_valid && (is_halt || is_stop) && state == sshc_pkg::SSHC_RUN) begin
                last_nop <= is_halt ? !halt_ok : !stop_ok;
            end
            if (state != sshc_pkg::SSHC_RUN && next_state != state) last_port <= pa_low;
        end
    end

    // ahb-lite: zero wait states, always okay, read data caught at address phase
    assign addr_phase = hsel && hready && htrans[1];
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            dp_write  <= 1'b0;
            dp_addr   <= 32'h0000_0000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            dp_write  <= addr_phase && hwrite;
            dp_addr   <= haddr;
            if (addr_phase && !hwrite) begin
                if (haddr == sshc_pkg::ADDR_CTRL) begin
                    hrdata <= {16'h0000, timer_modulo_value, 6'h00,
                               subclk_in_use, system_clock_select};
                end else if (haddr == sshc_pkg::ADDR_STATUS) begin
                    hrdata <= {25'h0, last_port, last_nop, last_vec, 2'h0, state};
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end

    // control register write in the data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            system_clock_select <= sshc_pkg::SYSCLK_RESET;
            subclk_in_use       <= 1'b0;
            timer_modulo_value  <= sshc_pkg::TMM_RESET;
        end else if (dp_write && dp_addr == sshc_pkg::ADDR_CTRL) begin
            system_clock_select <= hwdata[sshc_pkg::CTRL_SYSCLK];
            subclk_in_use       <= hwdata[sshc_pkg::CTRL_SUBCLK];
            timer_modulo_value  <= hwdata[sshc_pkg::CTRL_TMM_LSB +: 8];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_halt_entry: assert property (state == sshc_pkg::SSHC_RUN && is_halt && halt_ok
        |=> cpu_hold && main_osc_en) else $error("halt not entered");
    a_stop_osc_off: assert property (state == sshc_pkg::SSHC_STP |-> !main_osc_en)
        else $error("oscillator running in stop");
    a_halt2_wake: assert property (state == sshc_pkg::SSHC_HLT
        && halt_mode == sshc_pkg::OPER_TIMER && !req_flags.tm |=> state == sshc_pkg::SSHC_HLT)
        else $error("halt 2 left without timer flag");
    a_halt8_port: assert property (state == sshc_pkg::SSHC_HLT
        && halt_mode == sshc_pkg::OPER_ANY && pa_low |=> resume_pulse)
        else $error("port A did not wake halt 8");
    a_halt_a_tm: assert property (state == sshc_pkg::SSHC_HLT
        && halt_mode == sshc_pkg::OPER_TIMER_EN && req_flags.tm |=> state == sshc_pkg::SSHC_RUN)
        else $error("timer flag did not wake halt A");
    a_vector_en: assert property (take_vector |-> resume_pulse && master_irq_enable)
        else $error("vector without master enable");
    a_nop_halt: assert property (state == sshc_pkg::SSHC_RUN && is_halt && !halt_ok
        |=> instr_as_nop && !cpu_hold) else $error("bad halt not a no-op");
    a_nop_stop: assert property (state == sshc_pkg::SSHC_RUN && is_stop && !system_clock_select
        |=> state == sshc_pkg::SSHC_RUN && instr_as_nop) else $error("stop on subclock");
    a_stop_release: assert property (state == sshc_pkg::SSHC_STP ##1 state == sshc_pkg::SSHC_WAIT
        |-> timer_match_flag_clear && timer8_restart) else $error("stop release effects");
    a_wait_len: assert property (state == sshc_pkg::SSHC_WAIT && pre_wrap
        && stab_cnt < timer_modulo_value |=> state == sshc_pkg::SSHC_WAIT)
        else $error("wait ended early");
    a_watch_sub: assert property (subclk_in_use && $stable(subclk_in_use) |-> watch_run)
        else $error("watch timer stopped on subclock");
    a_master_di: assert property (instr_valid && instr_kind == sshc_pkg::SSHC_DI
        |=> !master_irq_enable) else $error("disable did not clear master");

    c_halt_vec:  cover property (state == sshc_pkg::SSHC_HLT ##1 take_vector);
    c_stop_wait: cover property (state == sshc_pkg::SSHC_WAIT ##1 state == sshc_pkg::SSHC_RUN);
    c_nop:       cover property (instr_as_nop);
endmodule // sshc_ctrl

// file: sshc_cpu_model.sv
// sequencer and interrupt source model that faces the standby controller
module sshc_cpu_model (
    input  wire logic             clk,
    input  wire logic             timer_match_flag_clear,
    output logic                  instr_valid,
    output sshc_pkg::sshc_instr_t instr_kind,
    output logic [3:0]            instr_operand,
    output sshc_pkg::sshc_irq_t   req_flags
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle sequencer, no pending requests
    initial begin
        instr_valid   = 1'b0;
        instr_kind    = sshc_pkg::SSHC_HALT;
        instr_operand = 4'h0;
        req_flags     = '0;
    end

    // one executed instruction: a single-cycle strobe, called just after an edge
    task automatic exec(input sshc_pkg::sshc_instr_t k, input logic [3:0] op);
        instr_valid   <= 1'b1;
        instr_kind    <= k;
        instr_operand <= op;
        @(posedge clk);
        instr_valid   <= 1'b0;
    endtask

    // peripherals raise their request flags
    task automatic raise(input sshc_pkg::sshc_irq_t v);
        req_flags <= req_flags | v;
    endtask

    // program clears flags, then lets a cycle pass before any standby entry
    task automatic drop(input sshc_pkg::sshc_irq_t v);
        req_flags <= req_flags & ~v;
        @(posedge clk);
    endtask

    // timer match flag follows the controller's clear strobe at stop release
    always @(posedge clk) begin
        if (timer_match_flag_clear)
            req_flags.tm <= 1'b0;
    end
endmodule // sshc_cpu_model

// file: standby_halt_stop_ctrl_bench.sv
// self-checking bench of the standby halt/stop controller
module standby_halt_stop_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PRE = 4;

    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  hsel, hwrite, hreadyout, hresp;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    logic [31:0]           haddr, hwdata, hrdata, rd;
    logic                  cpu_hold, resume_pulse, take_vector, instr_as_nop;
    logic                  master_irq_enable, tm_clr, t8_rst, w_rst, watch_run, main_osc_en;
    logic                  instr_valid;
    sshc_pkg::sshc_instr_t instr_kind;
    logic [3:0]            instr_operand, port_a, pa_out, pb_out, pb_latch;
    sshc_pkg::sshc_irq_t   req_flags, req_enables;
    logic                  hold, nop, vec;
    int                    fails = 0;
    int                    n_checks = 0;
    int                    n;

    always #5 clk = ~clk;

    sshc_ctrl #(.PRESCALE(PRE)) uut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .instr_valid(instr_valid), .instr_kind(instr_kind), .instr_operand(instr_operand),
        .cpu_hold(cpu_hold), .resume_pulse(resume_pulse), .take_vector(take_vector),
        .instr_as_nop(instr_as_nop), .master_irq_enable(master_irq_enable),
        .req_flags(req_flags), .req_enables(req_enables),
        .timer_match_flag_clear(tm_clr), .timer8_restart(t8_rst),
        .watch_restart(w_rst), .watch_run(watch_run), .main_osc_en(main_osc_en),
        .wake_port_a(port_a), .port_a_is_output(pa_out),
        .port_b_is_output(pb_out), .port_b_latch(pb_latch));

    sshc_cpu_model cpu (
        .clk(clk), .timer_match_flag_clear(tm_clr), .instr_valid(instr_valid),
        .instr_kind(instr_kind), .instr_operand(instr_operand), .req_flags(req_flags));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // single ahb-lite word transfer; read data taken at the data-phase edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        // select drops with the address phase so the data-phase cycle never starts a second transfer
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp okay", hresp, 0);
    endtask

    // issue one instruction, sample the controller's answer a cycle later
    task automatic run(input sshc_pkg::sshc_instr_t k, input logic [3:0] op);
        cpu.exec(k, op);
        @(posedge clk);
        hold = cpu_hold;
        nop  = instr_as_nop;
    endtask

    // bounded wait for execution to resume
    task automatic wake;
        n = 0;
        while (resume_pulse !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        vec = take_vector;
    endtask

    // stop release: strobes at wake, then the stabilisation wait of (1+1)*PRE cycles
    task automatic stop_wake(input logic wexp);
        n = 0;
        while (tm_clr !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("t8 restart", t8_rst, 1);
        chk("watch restart", w_rst, wexp);
        @(posedge clk);
        wake;
        chk("wait ok", n >= 2 * PRE - 1 && n <= 2 * PRE + 1, 1);
        chk("osc on", main_osc_en, 1);
        chk("tm flag", req_flags.tm, 0);
    endtask

    initial begin
        hsel = 1'b0;
        haddr = '0;
        hwrite = 1'b0;
        hsize = 3'h2;
        htrans = 2'h0;
        hwdata = '0;
        req_enables = '0;
        port_a = 4'hf;
        pa_out = 4'h0;
        pb_out = 4'hf;
        pb_latch = 4'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("master rst", master_irq_enable, 0);
        ahb(1'b0, sshc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl rst", rd, 32'h0000ff01);
        ahb(1'b0, 32'h0000_0010, 32'h0);
        chk("unmapped", rd, 32'h0);
        // halt 2: other enabled requests ignored, timer match vectors
        run(sshc_pkg::SSHC_EI, 4'h0);
        chk("master ei", master_irq_enable, 1);
        req_enables <= 4'b1010;
        run(sshc_pkg::SSHC_HALT, 4'h2);
        chk("halt2 hold", hold, 1);
        cpu.raise(4'b0010);
        repeat (6) @(posedge clk);
        chk("halt2 wtm", cpu_hold, 1);
        chk("halt osc", main_osc_en, 1);
        cpu.raise(4'b1000);
        wake;
        chk("halt2 vec", vec, 1);
        cpu.drop(4'b1111);
        // halt 8: disabled request stays, port A low resumes without vector
        req_enables <= 4'b0000;
        run(sshc_pkg::SSHC_HALT, 4'h8);
        cpu.raise(4'b0001);
        repeat (6) @(posedge clk);
        chk("halt8 dis", cpu_hold, 1);
        port_a <= 4'hb;
        wake;
        chk("port wake", n < 200 && vec === 1'b0, 1);
        port_a <= 4'hf;
        // halt A: timer wakes with own enable 0, no vector
        run(sshc_pkg::SSHC_HALT, 4'ha);
        chk("haltA hold", hold, 1);
        cpu.raise(4'b1000);
        wake;
        chk("haltA tm", n < 200 && vec === 1'b0, 1);
        cpu.drop(4'b1111);
        // halt 8: enabled watch request vectors
        req_enables <= 4'b0010;
        run(sshc_pkg::SSHC_HALT, 4'h8);
        cpu.raise(4'b0010);
        wake;
        chk("halt8 vec", n < 200 && vec === 1'b1, 1);
        cpu.drop(4'b1111);
        // every reserved halt operand is a no-operation
        for (int i = 0; i < 16; i++) begin
            if (i != 2 && i != 8 && i != 10) begin
                run(sshc_pkg::SSHC_HALT, 4'(i));
                chk("halt nop", {hold, nop}, 2'b01);
            end
        end
        // halt 8 entry conditions on port B, and port A output masking
        pb_latch <= 4'h4;
        run(sshc_pkg::SSHC_HALT, 4'h8);
        chk("pb latch", {hold, nop}, 2'b01);
        pb_latch <= 4'h0;
        pb_out <= 4'h7;
        run(sshc_pkg::SSHC_HALT, 4'h8);
        chk("pb input", {hold, nop}, 2'b01);
        pb_out <= 4'hf;
        pa_out <= 4'h1;
        port_a <= 4'he;
        repeat (3) @(posedge clk);
        run(sshc_pkg::SSHC_HALT, 4'h8);
        chk("pa output", hold, 1);
        pa_out <= 4'h0;
        wake;
        chk("pa wake", n < 200, 1);
        port_a <= 4'hf;
        run(sshc_pkg::SSHC_DI, 4'h0);
        chk("master di", master_irq_enable, 0);
        // stop under subclock, and with an enabled flag pending
        ahb(1'b1, sshc_pkg::ADDR_CTRL, 32'h0000_0100);
        run(sshc_pkg::SSHC_STOP, 4'h8);
        chk("stop sub", {hold, nop}, 2'b01);
        ahb(1'b1, sshc_pkg::ADDR_CTRL, 32'h0000_0101);
        cpu.raise(4'b0010);
        run(sshc_pkg::SSHC_STOP, 4'h8);
        chk("stop flag", {hold, nop}, 2'b01);
        cpu.drop(4'b1111);
        // stop 8: timer request ignored, port A low releases
        req_enables <= 4'b1010;
        run(sshc_pkg::SSHC_STOP, 4'h8);
        chk("stop osc", {hold, main_osc_en, watch_run}, 3'b100);
        cpu.raise(4'b1000);
        repeat (6) @(posedge clk);
        chk("stop tm", cpu_hold, 1);
        port_a <= 4'h7;
        stop_wake(1'b1);
        port_a <= 4'hf;
        // stop with subclock in use: watch keeps running, enabled request releases
        run(sshc_pkg::SSHC_EI, 4'h0);
        ahb(1'b1, sshc_pkg::ADDR_CTRL, 32'h0000_0103);
        run(sshc_pkg::SSHC_STOP, 4'h8);
        chk("sub watch", {hold, watch_run}, 2'b11);
        cpu.raise(4'b0010);
        stop_wake(1'b0);
        chk("stop vec", vec, 1);
        // status: last resume vectored, entered cleanly, no port wake, running
        ahb(1'b0, sshc_pkg::ADDR_STATUS, 32'h0);
        chk("status", rd, 32'(1) << sshc_pkg::STAT_VEC);
        test_done;
    end

    // hang guard, well beyond the hundred-odd cycles the sequence needs
    initial begin
        #200000;
        fails++;
        test_done;
    end
endmodule // standby_halt_stop_ctrl_bench
